//--- bcr_div.sv
`timescale 1ns/10ps
module bcr_div (
  // Clock, reset and freeze.
  input  logic                  clk,
  input  logic                  rstn,
  input  logic                  ce,
  // Request and result.
  input  logic                  start,
  input  bcr_pkg::bcr_div_req_t req,
  output logic                  done,
  output bcr_pkg::bcr_div_res_t res
);
  typedef struct packed {
    logic        busy;
    logic [4:0]  cnt;
    logic [31:0] den;
    logic [31:0] q;
    logic [31:0] r;
    logic        done;
  } bcr_div_st_t;

  bcr_div_st_t s;
  bcr_div_st_t next_s;
  logic [32:0] t;

  // Restoring division, one quotient bit per cycle.
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    t = {s.r, s.q[31]};
    if (start) begin
      next_s.busy = 1'b1;
      next_s.cnt  = 5'h00;
      next_s.den  = req.den;
      next_s.q    = req.num;
      next_s.r    = 32'h00000000;
    end else if (s.busy) begin
      next_s.q = {s.q[30:0], 1'b0};
      if (t >= {1'b0, s.den}) begin
        t = t - {1'b0, s.den};
        next_s.q[0] = 1'b1;
      end
      next_s.r   = t[31:0];
      next_s.cnt = s.cnt + 5'h01;
      if (s.cnt == 5'h1F) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign done    = s.done;
  assign res     = '{quo: s.q, rem: s.r};

  // ****************************************************************
  // Checks.
  // ****************************************************************
  localparam int LAT = bcr_pkg::DIV_CYC;

  property p_div_lat;
    @(posedge clk) disable iff (!rstn || !ce)
    start |-> ##LAT done;
  endproperty
  a_div_lat: assert property (p_div_lat) else $error("divider latency wrong");
endmodule

//--- bcr_enc_model.sv
`timescale 1ns/10ps
module bcr_enc_model (
  // Link.
  input  logic        ma,
  output logic        slo,
  // Frame content and faults.
  input  logic [31:0] pos,
  input  logic [5:0]  nbits,
  input  logic        bad_crc,
  input  logic        enc_err
);
  // ******************
  // Encoder frame.
  // ******************
  logic       q[$];
  logic [5:0] crc;
  logic       active = 1'b0;
  initial slo = 1'b1;
  function automatic logic [5:0] crc_of(input logic [31:0] p, input int n, input logic ne);
    logic [5:0] c;
    logic       b;
    c = 6'h00;
    for (int i = n + 1; i >= 0; i--) begin
      b = (i >= 2) ? p[i-2] : ((i == 1) ? ne : 1'b1);
      c = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? 6'h03 : 6'h00);
    end
    return c;
  endfunction
  // A frame is built when the clock first falls and shifted out on rising edges.
  always @(negedge ma) begin
    if (!active) begin
      active = 1'b1;
      crc = crc_of(pos, int'(nbits), !enc_err) ^ {5'h00, bad_crc};
      q = {1'b0, 1'b1, 1'b0};
      for (int i = int'(nbits) - 1; i >= 0; i--) q.push_back(pos[i]);
      q.push_back(!enc_err);
      q.push_back(1'b1);
      for (int i = 5; i >= 0; i--) q.push_back(!crc[i]);
    end
  end
  always @(posedge ma) begin
    if (active && q.size() > 0) begin
      slo <= q.pop_front();
    end else if (active) begin
      slo <= 1'b0;
      #2000;
      slo <= 1'b1;
      active = 1'b0;
    end
  end
endmodule

//--- bcr_pkg.sv
package bcr_pkg;
  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_NS       = 100;
  localparam int T_MA_HALF_NS = 400;
  localparam int MA_HALF      = (T_MA_HALF_NS / CLK_NS < 1) ? 1 : T_MA_HALF_NS / CLK_NS;
  localparam int T_GAP_NS     = 20000;
  localparam int GAP_CYC      = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_TOUT_NS    = 40000;
  localparam int TOUT_CYC     = (T_TOUT_NS / CLK_NS < 1) ? 1 : T_TOUT_NS / CLK_NS;
  localparam int ACK_MAX      = 16;
  localparam int DIV_CYC      = 33;

  // ****************************************************************
  // Frame format.
  // ****************************************************************
  localparam int         FRAME_MAX = 40;
  localparam int         POS_MAX   = 32;
  localparam int         CRC_W     = 6;
  localparam logic [5:0] CRC_POLY  = 6'h03;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CFG   = 8'h04;
  localparam logic [7:0] OFS_LINES = 8'h08;
  localparam logic [7:0] OFS_POLE  = 8'h0C;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  localparam logic [7:0] OFS_IST   = 8'h14;
  localparam logic [7:0] OFS_IMASK = 8'h18;
  localparam logic [7:0] OFS_REV   = 8'h1C;
  localparam logic [7:0] OFS_TICKS = 8'h20;
  localparam logic [7:0] OFS_ROTOR = 8'h24;
  localparam logic [7:0] OFS_RAW   = 8'h28;

  localparam int CTRL_RUN    = 0;
  localparam int CTRL_MODE   = 1;
  localparam int CTRL_ANALOG = 3;
  localparam int CFG_PB      = 0;
  localparam int CFG_ST      = 8;
  localparam int STAT_VALID  = 0;
  localparam int STAT_NEED   = 1;
  localparam int STAT_BUSY   = 2;
  localparam int IRQ_FRAME   = 0;
  localparam int IRQ_CRC     = 1;
  localparam int IRQ_ENC     = 2;

  localparam logic [5:0]  RST_POS_BITS = 6'h20;
  localparam logic [5:0]  RST_ST_BITS  = 6'h14;
  localparam logic [31:0] RST_LINES    = 32'h00000800;
  localparam logic [31:0] RST_POLE     = 32'h00000800;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {MODE_REL, MODE_ROT, MODE_ABS, MODE_RSV} bcr_mode_t;

  typedef enum logic [3:0] {
    L_IDLE, L_ACK, L_CDS, L_DATA, L_ERR, L_WARN, L_CRC, L_TOUT, L_DIV1, L_DIV2
  } bcr_link_t;

  typedef struct packed {
    logic [31:0] num;
    logic [31:0] den;
  } bcr_div_req_t;

  typedef struct packed {
    logic [31:0] quo;
    logic [31:0] rem;
  } bcr_div_res_t;
endpackage

//--- bcr_receiver.sv
// Contract
// - Frames up to 40 bits; position field at most 32 bits.
// - Each frame is checked by a 6-bit CRC, polynomial 0x43.
// - Relative-linear position starts at zero after reset, then signed.
// - Relative-linear mode flags commutation search and homing as needed.
// - Rotative mode splits position into single-turn and multi-turn parts.
// - Absolute-linear maps position onto any line count, no homing needed.
// - Rotor position derives from absolute position modulo the pole length; rotative uses the single-turn part, relative-linear the relative one.
// - While the encoder is used as analogue, no serial frames run; a frame already under way when analogue use is set still completes.
// - No parameter storage or identification readout over the link.
// - Line count scales counts so one revolution reports as one.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module bcr_receiver #(
  parameter int ACK_LIMIT = bcr_pkg::ACK_MAX,
  parameter int TOUT_LIM  = bcr_pkg::TOUT_CYC,
  parameter int GAP_LIM   = bcr_pkg::GAP_CYC
) (
  // Clock, reset and freeze.
  input  logic        pclk,
  input  logic        presetn,
  input  logic        ce,
  // APB slave.
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Encoder link.
  output logic        ma,
  input  logic        slo,
  // Interrupt.
  output logic        irq
);
  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic                  run;
    bcr_pkg::bcr_mode_t    mode;
    logic                  analog;
    logic                  need;
    logic [5:0]            pos_bits;
    logic [5:0]            st_bits;
    logic [31:0]           lines;
    logic [31:0]           pole;
    logic [2:0]            ist;
    logic [2:0]            imask;
    logic                  irq;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  ma;
    logic                  slo_s1;
    logic                  slo_s2;
    bcr_pkg::bcr_link_t    lst;
    logic [8:0]            cnt;
    logic [5:0]            bitcnt;
    logic                  seen_low;
    logic                  abort;
    logic [31:0]           shreg;
    logic [5:0]            crc;
    logic [5:0]            crc_rx;
    logic                  nerr;
    logic [31:0]           raw;
    logic                  ref_taken;
    logic [31:0]           ref_pos;
    logic                  neg;
    logic [31:0]           mag;
    logic [31:0]           mt;
    logic                  pos_valid;
    logic [31:0]           rev;
    logic [31:0]           ticks;
    logic [31:0]           rotor;
    logic                  div_go;
    bcr_pkg::bcr_div_req_t div_req;
  } bcr_state_t;

  bcr_state_t            s;
  bcr_state_t            n;
  logic                  div_done;
  bcr_pkg::bcr_div_res_t div_res;
  logic                  hit;
  logic [31:0]           rd;
  logic                  acc;
  logic [2:0]            w1c;
  logic [2:0]            evs;
  logic                  bit_ev;
  logic                  slo2;
  logic                  ev_bad;
  logic                  ev_crc;
  logic                  resp_ok;
  logic [5:0]            sh;
  logic [31:0]           x;
  logic signed [31:0]    d;
  logic [31:0]           q;
  logic [31:0]           r;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
    logic fb;
    fb = c[5] ^ b;
    return {c[4:0], 1'b0} ^ (fb ? bcr_pkg::CRC_POLY : 6'h00);
  endfunction

  function automatic logic [31:0] bcr_mask(input logic [5:0] w);
    return (w >= 6'h20) ? 32'hFFFFFFFF : ((32'h00000001 << w) - 32'h00000001);
  endfunction

  function automatic logic [31:0] apply_sign(input logic ng, input logic [31:0] v);
    return ng ? (32'h00000000 - v) : v;
  endfunction

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    n       = s;
    w1c     = 3'h0;
    evs     = 3'h0;
    bit_ev  = 1'b0;
    ev_bad  = 1'b0;
    ev_crc  = 1'b0;
    resp_ok = 1'b0;
    sh      = 6'h00;
    x       = 32'h00000000;
    d       = 32'sh00000000;
    q       = div_res.quo;
    r       = div_res.rem;
    hit     = 1'b1;
    rd      = 32'h00000000;
    n.div_go = 1'b0;
    n.slo_s1 = slo;
    n.slo_s2 = s.slo_s1;
    slo2     = s.slo_s2;

    unique case (paddr)
      bcr_pkg::OFS_CTRL:  rd = {28'h0000000, s.analog, s.mode, s.run};
      bcr_pkg::OFS_CFG:   rd = {18'h00000, s.st_bits, 2'h0, s.pos_bits};
      bcr_pkg::OFS_LINES: rd = s.lines;
      bcr_pkg::OFS_POLE:  rd = s.pole;
      bcr_pkg::OFS_STAT:  rd = {29'h00000000, s.lst != bcr_pkg::L_IDLE, s.need, s.pos_valid};
      bcr_pkg::OFS_IST:   rd = {29'h00000000, s.ist};
      bcr_pkg::OFS_IMASK: rd = {29'h00000000, s.imask};
      bcr_pkg::OFS_REV:   rd = s.rev;
      bcr_pkg::OFS_TICKS: rd = s.ticks;
      bcr_pkg::OFS_ROTOR: rd = s.rotor;
      bcr_pkg::OFS_RAW:   rd = s.raw;
      default:            hit = 1'b0;
    endcase

    // APB: setup loads the answer, the access edge with pready commits.
    n.pready = 1'b0;
    if (psel && !penable && !s.pready) begin
      n.pready  = 1'b1;
      n.pslverr = !hit;
      n.prdata  = (pwrite || !hit) ? 32'h00000000 : rd;
    end
    acc = psel && penable && s.pready;
    if (acc && pwrite && !s.pslverr) begin
      unique case (paddr)
        bcr_pkg::OFS_CTRL: begin
          n.run    = pwdata[bcr_pkg::CTRL_RUN];
          n.mode   = bcr_pkg::bcr_mode_t'(pwdata[bcr_pkg::CTRL_MODE +: 2]);
          n.analog = pwdata[bcr_pkg::CTRL_ANALOG];
        end
        bcr_pkg::OFS_CFG: begin
          n.pos_bits = pwdata[bcr_pkg::CFG_PB +: 6];
          if (n.pos_bits == 6'h00 || n.pos_bits > 6'h20) begin
            n.pos_bits = bcr_pkg::RST_POS_BITS;
          end
          n.st_bits = pwdata[bcr_pkg::CFG_ST +: 6];
        end
        bcr_pkg::OFS_LINES: n.lines = pwdata;
        bcr_pkg::OFS_POLE:  n.pole = pwdata;
        bcr_pkg::OFS_IST:   w1c = pwdata[2:0];
        bcr_pkg::OFS_IMASK: n.imask = pwdata[2:0];
        default: begin
        end
      endcase
    end
    n.need = (n.mode == bcr_pkg::MODE_REL);

    // Clock generation during the frame; bits are taken on each rising edge.
    if (s.lst inside {bcr_pkg::L_ACK, bcr_pkg::L_CDS, bcr_pkg::L_DATA,
                      bcr_pkg::L_ERR, bcr_pkg::L_WARN, bcr_pkg::L_CRC}) begin
      if (s.cnt == 9'(bcr_pkg::MA_HALF - 1)) begin
        n.cnt  = 9'h000;
        n.ma   = !s.ma;
        bit_ev = !s.ma;
      end else begin
        n.cnt = s.cnt + 9'h001;
      end
    end

    unique case (s.lst)
      bcr_pkg::L_IDLE: begin
        n.ma = 1'b1;
        if (!s.run || s.analog) begin
          n.cnt = 9'h000;
        end else if (s.cnt == 9'(GAP_LIM - 1)) begin
          n.lst      = bcr_pkg::L_ACK;
          n.ma       = 1'b0;
          n.cnt      = 9'h000;
          n.bitcnt   = 6'h00;
          n.seen_low = 1'b0;
          n.abort    = 1'b0;
        end else begin
          n.cnt = s.cnt + 9'h001;
        end
      end
      bcr_pkg::L_ACK: begin
        if (bit_ev) begin
          n.bitcnt = s.bitcnt + 6'h01;
          if (!slo2) begin
            n.seen_low = 1'b1;
          end else if (s.seen_low) begin
            n.lst = bcr_pkg::L_CDS;
          end else if (s.bitcnt == 6'(ACK_LIMIT - 1)) begin
            n.abort    = 1'b1;
            n.lst      = bcr_pkg::L_TOUT;
            n.cnt      = 9'h000;
            n.seen_low = 1'b0;
          end
          if (!slo2 && s.bitcnt == 6'(ACK_LIMIT - 1)) begin
            n.abort    = 1'b1;
            n.lst      = bcr_pkg::L_TOUT;
            n.cnt      = 9'h000;
            n.seen_low = 1'b0;
          end
        end
      end
      bcr_pkg::L_CDS: begin
        // The data-channel bit is dropped; no register traffic is started.
        if (bit_ev) begin
          n.lst    = bcr_pkg::L_DATA;
          n.bitcnt = 6'h00;
          n.crc    = 6'h00;
        end
      end
      bcr_pkg::L_DATA: begin
        if (bit_ev) begin
          n.shreg  = {s.shreg[30:0], slo2};
          n.crc    = crc_step(s.crc, slo2);
          n.bitcnt = s.bitcnt + 6'h01;
          if (s.bitcnt == s.pos_bits - 6'h01) begin
            n.lst = bcr_pkg::L_ERR;
          end
        end
      end
      bcr_pkg::L_ERR: begin
        if (bit_ev) begin
          n.nerr = slo2;
          n.crc  = crc_step(s.crc, slo2);
          n.lst  = bcr_pkg::L_WARN;
        end
      end
      bcr_pkg::L_WARN: begin
        if (bit_ev) begin
          n.crc    = crc_step(s.crc, slo2);
          n.lst    = bcr_pkg::L_CRC;
          n.bitcnt = 6'h00;
        end
      end
      bcr_pkg::L_CRC: begin
        if (bit_ev) begin
          n.crc_rx = {s.crc_rx[4:0], slo2};
          n.bitcnt = s.bitcnt + 6'h01;
          if (s.bitcnt == 6'(bcr_pkg::CRC_W - 1)) begin
            n.lst      = bcr_pkg::L_TOUT;
            n.cnt      = 9'h000;
            n.seen_low = 1'b0;
          end
        end
      end
      bcr_pkg::L_TOUT: begin
        n.ma    = 1'b1;
        n.cnt   = s.cnt + 9'h001;
        resp_ok = s.seen_low && slo2;
        if (!slo2) begin
          n.seen_low = 1'b1;
        end
        if (resp_ok || s.cnt == 9'(TOUT_LIM - 1)) begin
          n.cnt = 9'h000;
          n.lst = bcr_pkg::L_IDLE;
          // The CRC goes out inverted on the line.
          ev_crc = !s.abort && (s.crc_rx != ~s.crc);
          ev_bad = ev_crc || s.abort || !resp_ok || !s.nerr;
          evs[bcr_pkg::IRQ_CRC] = ev_crc;
          evs[bcr_pkg::IRQ_ENC] = ev_bad && !ev_crc;
          if (!ev_bad) begin
            n.raw = s.shreg & bcr_mask(s.pos_bits);
            n.mt  = 32'h00000000;
            n.neg = 1'b0;
            unique case (s.mode)
              bcr_pkg::MODE_REL: begin
                if (!s.ref_taken) begin
                  n.ref_pos   = n.raw;
                  n.ref_taken = 1'b1;
                end
                sh = 6'h20 - s.pos_bits;
                x  = n.raw - n.ref_pos;
                d  = $signed(x << sh) >>> sh;
                n.neg = d[31];
                n.mag = n.neg ? (32'h00000000 - d) : d;
              end
              bcr_pkg::MODE_ROT: begin
                n.mt  = n.raw >> s.st_bits;
                n.mag = n.raw & bcr_mask(s.st_bits);
              end
              bcr_pkg::MODE_ABS, bcr_pkg::MODE_RSV: begin
                n.mag = n.raw;
              end
            endcase
            n.div_go      = 1'b1;
            n.div_req.num = n.mag;
            n.div_req.den = s.lines;
            n.lst         = bcr_pkg::L_DIV1;
          end
        end
      end
      bcr_pkg::L_DIV1: begin
        if (div_done) begin
          n.rev         = s.mt + apply_sign(s.neg, q);
          n.ticks       = apply_sign(s.neg, r);
          n.div_go      = 1'b1;
          n.div_req.num = s.mag;
          n.div_req.den = s.pole;
          n.lst         = bcr_pkg::L_DIV2;
        end
      end
      bcr_pkg::L_DIV2: begin
        if (div_done) begin
          n.rotor     = apply_sign(s.neg, r);
          n.pos_valid = 1'b1;
          n.lst       = bcr_pkg::L_IDLE;
          evs[bcr_pkg::IRQ_FRAME] = 1'b1;
        end
      end
    endcase

    // A new event wins over a clear in the same cycle.
    n.ist = (s.ist & ~w1c) | evs;
    n.irq = |(n.ist & n.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.mode     <= bcr_pkg::MODE_REL;
      s.need     <= 1'b1;
      s.pos_bits <= bcr_pkg::RST_POS_BITS;
      s.st_bits  <= bcr_pkg::RST_ST_BITS;
      s.lines    <= bcr_pkg::RST_LINES;
      s.pole     <= bcr_pkg::RST_POLE;
      s.ma       <= 1'b1;
      s.slo_s1   <= 1'b1;
      s.slo_s2   <= 1'b1;
      s.lst      <= bcr_pkg::L_IDLE;
    end else if (ce) begin
      s <= n;
    end
  end

  bcr_div u_div (
    .clk   (pclk),
    .rstn  (presetn),
    .ce    (ce),
    .start (s.div_go),
    .req   (s.div_req),
    .done  (div_done),
    .res   (div_res)
  );

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign ma      = s.ma;
  assign irq     = s.irq;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence s_bad_end;
    s.lst == bcr_pkg::L_TOUT && ev_bad;
  endsequence

  property p_len;
    s.lst == bcr_pkg::L_DATA |-> s.bitcnt < s.pos_bits && s.pos_bits <= 6'h20;
  endproperty
  a_len: assert property (p_len) else $error("position field too long");

  property p_crc;
    ev_crc |=> s.ist[bcr_pkg::IRQ_CRC] && s.lst == bcr_pkg::L_IDLE;
  endproperty
  a_crc: assert property (p_crc) else $error("CRC error not flagged");

  property p_rel_zero;
    $rose(s.ref_taken) |-> s.ref_pos == s.raw && s.mag == 32'h00000000;
  endproperty
  a_rel_zero: assert property (p_rel_zero) else $error("first position not zero");

  property p_need;
    s.need == (s.mode == bcr_pkg::MODE_REL);
  endproperty
  a_need: assert property (p_need) else $error("homing flag wrong");

  property p_split;
    s.div_go && s.lst == bcr_pkg::L_DIV1 && s.mode == bcr_pkg::MODE_ROT
      |-> s.mt == (s.raw >> s.st_bits) && s.div_req.num == (s.raw & bcr_mask(s.st_bits));
  endproperty
  a_split: assert property (p_split) else $error("turn split wrong");

  property p_pole;
    s.div_go && s.lst == bcr_pkg::L_DIV2 |-> s.div_req.den == s.pole;
  endproperty
  a_pole: assert property (p_pole) else $error("pole length not used");

  property p_analog;
    s.analog && s.lst == bcr_pkg::L_IDLE |=> s.lst == bcr_pkg::L_IDLE && s.ma;
  endproperty
  a_analog: assert property (p_analog) else $error("frame started in analogue use");

  property p_scale;
    s.div_go && s.lst == bcr_pkg::L_DIV1 |-> s.div_req.den == s.lines;
  endproperty
  a_scale: assert property (p_scale) else $error("line count not used");

  property p_keep;
    s_bad_end |=> $stable(s.rev) && $stable(s.rotor) ##1 $stable(s.ticks);
  endproperty
  a_keep: assert property (p_keep) else $error("position changed on bad frame");

  property p_irq;
    s.irq == |(s.ist & s.imask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_apb;
    psel && !penable && !s.pready |=> s.pready ##1 !s.pready;
  endproperty
  a_apb: assert property (p_apb) else $error("pready timing wrong");
endmodule

//--- bcr_receiver_test.sv
`timescale 1ns/10ps
module bcr_receiver_test;
  // ******************
  // Bench.
  // ******************
  typedef struct packed {
    logic [1:0]  mode;
    logic [31:0] cfg;
    logic [31:0] lines;
    logic [31:0] pole;
    logic [31:0] pos;
    logic [5:0]  nbits;
    logic [31:0] rev;
    logic [31:0] ticks;
    logic [31:0] rotor;
  } bcr_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ma;
  logic        slo;
  logic        irq;
  logic [31:0] pos = 32'h0;
  logic [5:0]  nbits = 6'h20;
  logic        bad_crc = 1'b0;
  logic        enc_err = 1'b0;
  logic [31:0] rdata;
  logic        rerr;
  int          n_fail = 0;
  int          n_checks = 0;
  int          nlow = 0;
  bcr_row_t    rows [4] = '{
    '{2'h1, 32'h0C18, 32'h3E8, 32'h1F4, 32'h345ABC, 6'h18, 32'h347, 32'h2EC, 32'hF8},
    '{2'h1, 32'h0A11, 32'h12C, 32'hA, 32'h1ABCD, 6'h11, 32'h6D, 32'h49, 32'h3},
    '{2'h2, 32'h1420, 32'h3E8, 32'h3E8, 32'h1E240, 6'h20, 32'h7B, 32'h1C8, 32'h1C8},
    '{2'h3, 32'h1420, 32'h800, 32'h800, 32'hFFFFFFFF, 6'h20, 32'h1FFFFF, 32'h7FF, 32'h7FF}
  };
  always #50 pclk = ~pclk;
  bcr_receiver #(.ACK_LIMIT(16), .TOUT_LIM(40), .GAP_LIM(20)) i_bcr_receiver (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ma(ma), .slo(slo), .irq(irq)
  );
  bcr_enc_model i_bcr_enc_model (
    .ma(ma), .slo(slo), .pos(pos), .nbits(nbits), .bad_crc(bad_crc), .enc_err(enc_err)
  );
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t == 20) n_fail++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask
  task automatic stat_is(input logic [1:0] e);
    apb(1'b0, bcr_pkg::OFS_STAT, 32'h0);
    chk("stat", {30'h0, e}, rdata & 32'h3);
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int t;
    t = 0;
    do begin
      apb(1'b0, a, 32'h0);
      t++;
    end while (rdata[b] !== v && t < 500);
    chk("wait", {31'h0, v}, {31'h0, rdata[b]});
  endtask
  task automatic restart(input logic [1:0] m);
    apb(1'b1, bcr_pkg::OFS_IST, 32'h7);
    apb(1'b1, bcr_pkg::OFS_CTRL, {29'h0, m, 1'b1});
    wait_bit(bcr_pkg::OFS_IST, bcr_pkg::IRQ_FRAME, 1'b1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("irq", 32'h0, {31'h0, irq});
    rd(bcr_pkg::OFS_CFG, 32'h1420, "cfg");
    rd(bcr_pkg::OFS_LINES, 32'h800, "lines");
    rd(bcr_pkg::OFS_POLE, 32'h800, "pole");
    stat_is(2'h2);
    rd(8'h40, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, rerr});
    pos <= 32'h00000064;
    restart(2'h0);
    rd(bcr_pkg::OFS_REV, 32'h0, "rev");
    rd(bcr_pkg::OFS_TICKS, 32'h0, "ticks");
    stat_is(2'h3);
    pos <= 32'h1067;
    repeat (2) restart(2'h0);
    rd(bcr_pkg::OFS_REV, 32'h2, "rev");
    rd(bcr_pkg::OFS_TICKS, 32'h3, "ticks");
    rd(bcr_pkg::OFS_ROTOR, 32'h3, "rotor");
    foreach (rows[i]) begin
      apb(1'b1, bcr_pkg::OFS_CTRL, 32'h0);
      wait_bit(bcr_pkg::OFS_STAT, bcr_pkg::STAT_BUSY, 1'b0);
      apb(1'b1, bcr_pkg::OFS_CFG, rows[i].cfg);
      apb(1'b1, bcr_pkg::OFS_LINES, rows[i].lines);
      apb(1'b1, bcr_pkg::OFS_POLE, rows[i].pole);
      pos <= rows[i].pos;
      nbits <= rows[i].nbits;
      restart(rows[i].mode);
      rd(bcr_pkg::OFS_REV, rows[i].rev, "rev");
      rd(bcr_pkg::OFS_TICKS, rows[i].ticks, "ticks");
      rd(bcr_pkg::OFS_ROTOR, rows[i].rotor, "rotor");
      stat_is(2'h1);
    end
    // Freeze a running frame while the link clock is low; it must resume cleanly.
    @(negedge ma);
    @(posedge pclk);
    ce <= 1'b0;
    repeat (50) @(posedge pclk) if (ma !== 1'b0) nlow++;
    ce <= 1'b1;
    chk("ma frozen", 32'h0, 32'(nlow));
    apb(1'b1, bcr_pkg::OFS_IST, 32'h7);
    wait_bit(bcr_pkg::OFS_IST, bcr_pkg::IRQ_FRAME, 1'b1);
    rd(bcr_pkg::OFS_IST, 32'h1, "ist");
    apb(1'b1, bcr_pkg::OFS_IMASK, 32'h2);
    bad_crc <= 1'b1;
    apb(1'b1, bcr_pkg::OFS_IST, 32'h7);
    wait_bit(bcr_pkg::OFS_IST, bcr_pkg::IRQ_CRC, 1'b1);
    chk("irq", 32'h1, {31'h0, irq});
    rd(bcr_pkg::OFS_REV, 32'h1FFFFF, "rev");
    bad_crc <= 1'b0;
    enc_err <= 1'b1;
    wait_bit(bcr_pkg::OFS_IST, bcr_pkg::IRQ_ENC, 1'b1);
    apb(1'b1, bcr_pkg::OFS_IST, 32'h7);
    wait_bit(bcr_pkg::OFS_IST, bcr_pkg::IRQ_ENC, 1'b1);
    chk("irq", 32'h0, {31'h0, irq});
    rd(bcr_pkg::OFS_TICKS, 32'h7FF, "ticks");
    apb(1'b1, bcr_pkg::OFS_CTRL, 32'h0);
    enc_err <= 1'b0;
    wait_bit(bcr_pkg::OFS_STAT, bcr_pkg::STAT_BUSY, 1'b0);
    apb(1'b1, bcr_pkg::OFS_IST, 32'h7);
    rd(bcr_pkg::OFS_IST, 32'h0, "ist");
    apb(1'b1, bcr_pkg::OFS_CTRL, 32'h9);
    repeat (600) @(posedge pclk) if (ma !== 1'b1) nlow++;
    chk("ma low", 32'h0, 32'(nlow));
    rd(bcr_pkg::OFS_IST, 32'h0, "ist");
    // A second reset must take a new reference position.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("irq", 32'h0, {31'h0, irq});
    stat_is(2'h2);
    rd(bcr_pkg::OFS_REV, 32'h0, "rev");
    apb(1'b1, bcr_pkg::OFS_CFG, 32'h0000003F);
    rd(bcr_pkg::OFS_CFG, 32'h00000020, "cfg");
    pos <= 32'h00000777;
    restart(2'h0);
    rd(bcr_pkg::OFS_REV, 32'h0, "rev");
    rd(bcr_pkg::OFS_TICKS, 32'h0, "ticks");
    tally_and_finish();
  end
endmodule
